// File: design/p0g_consts.vh
// Purpose: constants for the port 0 general-purpose pin block
// Assumes: APB slave, 32-bit data, one aligned word per register
// Notes:   offsets are byte addresses inside the block's window
`ifndef P0G_CONSTS_VH
`define P0G_CONSTS_VH

// ---------------------------------------------------------------
// register map
// ---------------------------------------------------------------
`define P0G_OFS_OUT_LATCH   12'h000
`define P0G_OFS_DIR         12'h004
`define P0G_OFS_PULLUP_EN   12'h008
`define P0G_OFS_RMW_LATCH   12'h00C
`define P0G_OFS_STANDBY     12'h010
`define P0G_OFS_IRQ_EN      12'h014

// ---------------------------------------------------------------
// widths, fields and reset values
// ---------------------------------------------------------------
`define P0G_PINS            8
`define P0G_ADDR_W          12
`define P0G_RST_OUT_LATCH   8'h00
`define P0G_RST_DIR         8'h00
`define P0G_RST_PULLUP_EN   8'h00
`define P0G_RST_IRQ_EN      8'h00
`define P0G_STB_FLOAT_BIT   0
`define P0G_STB_STOP_BIT    1
`define P0G_STB_WATCH_BIT   2
`define P0G_UNMAPPED_READ   32'h00000000

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define P0G_SYNC_STAGES     2

`endif

// File: design/p0g_sync.v
// Purpose: two-flop synchroniser for the eight port pin inputs
// Assumes: single clock domain pclk, asynchronous active-low reset
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ns
`default_nettype none

module p0g_sync
(
   input  wire       pclk,
   input  wire       presetn,
   input  wire [7:0] din,
   output reg  [7:0] dout
);

   reg [7:0] stage1;

   // ------------------------------------------------------------
   // two-stage capture
   // ------------------------------------------------------------
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         stage1 <= 8'h00;
         dout   <= 8'h00;
      end
      else
      begin
         stage1 <= din;
         dout   <= stage1;
      end
   end

endmodule // p0g_sync

`default_nettype wire

// File: design/p0g_port.v
// Purpose: port 0 eight-pin general-purpose I/O with pull-ups
// Assumes: APB slave on pclk; pins are split into in/out/enable
// Notes:   pull-up is a control output to the pad, not a level
//
// Notes on behaviour
// - output mode: latch bit 0 drives pin low, 1 drives high
// - plain data read gives input pin levels and output pin latch bits outside float; READ_MODIFY_WRITE_ACCESS read gives latch
// - plain data readback may differ from last written value
// - direction and pull-up registers read back what was written
// - direction bit 0 means input, 1 means output drive
// - pull-up bit 0 disables, 1 enables the pin's pull-up
// - register bit n belongs to pin n, all eight bits used
// - after reset data, direction and pull-up all hold zero
// - pin n feeds external interrupt input n
// - unimplemented address read returns zero and flags pslverr
// - data write with pin as input updates the latch only
// - pull-up disconnected while the pin output drives low
// - float bit set in stop/watch: pins hi-Z, input forced low unless its interrupt is enabled
`timescale 1ns/1ns
`default_nettype none

`include "p0g_consts.vh"

module p0g_port
(
   input  wire        pclk,
   input  wire        presetn,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   input  wire [3:0]  pstrb,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        stop_mode,
   input  wire        watch_mode,
   input  wire [7:0]  port0_pin_in,
   output reg  [7:0]  port0_pin_out,
   output reg  [7:0]  port0_pin_oe,
   output reg  [7:0]  port0_pullup_on,
   output reg  [7:0]  ext_irq_in
);

   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   reg  [7:0] port0_out_latch;
   reg  [7:0] port0_dir;
   reg  [7:0] port0_pullup_en;
   reg  [2:0] standby_control_reg;
   reg  [7:0] ext_irq_enable;
   wire [7:0] pin_sync;
   reg  [7:0] next_pin_out;
   reg  [7:0] next_pin_oe;
   reg  [7:0] next_pullup_on;
   reg  [7:0] next_irq_in;
   reg  [31:0] next_prdata;
   reg         next_pslverr;
   wire        standby_float;
   wire        setup_phase;
   wire        wr_strobe;
   wire        hit_latch;
   wire        hit_rmw;
   wire        hit_dir;
   wire        hit_pull;
   wire        hit_stb;
   wire        hit_irqen;
   wire        hit_any;
   wire        wr_ok;
   wire [7:0]  pin_gated;
   wire [7:0]  pin_view;

   // true when the bus address selects the given register word
   function reg_hit;
      input [11:0] a;
      input [11:0] ofs;
      begin
         reg_hit = (a == ofs);
      end
   endfunction

   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   // one compare per register, used by the write enables and the write error flag
   assign hit_latch = reg_hit(paddr, `P0G_OFS_OUT_LATCH);
   assign hit_rmw   = reg_hit(paddr, `P0G_OFS_RMW_LATCH);
   assign hit_dir   = reg_hit(paddr, `P0G_OFS_DIR);
   assign hit_pull  = reg_hit(paddr, `P0G_OFS_PULLUP_EN);
   assign hit_stb   = reg_hit(paddr, `P0G_OFS_STANDBY);
   assign hit_irqen = reg_hit(paddr, `P0G_OFS_IRQ_EN);
   assign hit_any   = hit_latch || hit_rmw || hit_dir || hit_pull ||
                      hit_stb || hit_irqen;

   // ------------------------------------------------------------
   // pin input synchroniser
   // ------------------------------------------------------------
   // synchronise pin inputs
   p0g_sync u_sync
   (
      .pclk    (pclk),
      .presetn (presetn),
      .din     (port0_pin_in),
      .dout    (pin_sync)
   );

   // ------------------------------------------------------------
   // apb handshake
   // ------------------------------------------------------------
   // no wait state: pready rises in the first access cycle, which
   // gives prdata a registered path with no combinational decode
   assign setup_phase = psel && !penable;
   assign wr_strobe   = psel && penable && pready && pwrite;
   // only the low byte lane carries register bits
   assign wr_ok       = wr_strobe && pstrb[0];

   // pready pulses once, so back-to-back transfers each get one edge
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready <= 1'b0;
      end
      else
      begin
         pready <= setup_phase;
      end
   end

   // error travels with pready and never outlives it
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pslverr <= 1'b0;
      end
      else
      begin
         pslverr <= setup_phase ? next_pslverr : 1'b0;
      end
   end

   // read data held until the next read, writes leave it alone
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata <= 32'h00000000;
      end
      else if (setup_phase && !pwrite)
      begin
         prdata <= next_prdata;
      end
   end

   // read mux and error decode during setup
   always @*
   begin
      next_pslverr = 1'b0;
      next_prdata  = 32'h00000000;
      case (paddr)
         `P0G_OFS_OUT_LATCH : next_prdata = {24'h000000, pin_view};
         `P0G_OFS_RMW_LATCH : next_prdata = {24'h000000, port0_out_latch};
         `P0G_OFS_DIR       : next_prdata = {24'h000000, port0_dir};
         `P0G_OFS_PULLUP_EN : next_prdata = {24'h000000, port0_pullup_en};
         `P0G_OFS_STANDBY   : next_prdata = {29'h0000000,
                                             standby_control_reg};
         `P0G_OFS_IRQ_EN    : next_prdata = {24'h000000, ext_irq_enable};
         default :
         begin
            next_prdata  = `P0G_UNMAPPED_READ;
            next_pslverr = 1'b1;
         end
      endcase
      // writes to a hole are dropped but flagged
      if (pwrite && !hit_any)
      begin
         next_pslverr = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // register writes
   // ------------------------------------------------------------
   // one process per register keeps each enable easy to follow
   // holes are never written; such a write only flags
   // write lands at the completing edge

   // data latch, reached through both the plain and rmw words
   // zero after reset
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port0_out_latch <= `P0G_RST_OUT_LATCH;
      end
      else if (wr_ok && (hit_latch || hit_rmw))
      begin
         port0_out_latch <= pwdata[7:0];
      end
   end

   // direction, plain storage
   // reads back as written
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port0_dir <= `P0G_RST_DIR;
      end
      else if (wr_ok && hit_dir)
      begin
         port0_dir <= pwdata[7:0];
      end
   end

   // pull-up enables, plain storage
   // reads back as written
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port0_pullup_en <= `P0G_RST_PULLUP_EN;
      end
      else if (wr_ok && hit_pull)
      begin
         port0_pullup_en <= pwdata[7:0];
      end
   end

   // standby control: float select plus software stop and watch
   // stop and watch bits only count with the float bit set
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         standby_control_reg <= 3'b000;
      end
      else if (wr_ok && hit_stb)
      begin
         standby_control_reg <= pwdata[2:0];
      end
   end

   // interrupt enables, which keep a pin's input alive in float
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ext_irq_enable <= `P0G_RST_IRQ_EN;
      end
      else if (wr_ok && hit_irqen)
      begin
         ext_irq_enable <= pwdata[7:0];
      end
   end

   // ------------------------------------------------------------
   // pad control
   // ------------------------------------------------------------
   assign standby_float = standby_control_reg[`P0G_STB_FLOAT_BIT] &&
                          (stop_mode || watch_mode ||
                           standby_control_reg[`P0G_STB_STOP_BIT] ||
                           standby_control_reg[`P0G_STB_WATCH_BIT]);

   // ------------------------------------------------------------
   // pin view for reads and interrupts
   // ------------------------------------------------------------
   // input locked low in float unless its interrupt is on
   assign pin_gated = standby_float ? (pin_sync & ext_irq_enable) :
                      pin_sync;

   // outside float, output pins read their latch, input pins the pad
   // the latch path also hides the two-flop lag after a write
   // limitation: a pin overdriven against its drive reads as latch
   assign pin_view = standby_float ? pin_gated :
                     ((port0_dir & port0_out_latch) |
                      (~port0_dir & pin_sync));

   // per-bit pad logic, bit n to pin n
   always @*
   begin
      // bit n maps to pin n
      next_pin_oe  = port0_dir;
      next_pin_out = port0_out_latch;
      // no pull-up on a low drive
      next_pullup_on = port0_pullup_en &
                       ~(port0_dir & ~port0_out_latch);
      next_irq_in = pin_gated;
      if (standby_float)
      begin
         next_pin_oe    = 8'h00;
         next_pullup_on = 8'h00;
      end
   end

   // registered drive value and enable, so pads switch cleanly
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port0_pin_out <= 8'h00;
         port0_pin_oe  <= 8'h00;
      end
      else
      begin
         port0_pin_out <= next_pin_out;
         port0_pin_oe  <= next_pin_oe;
      end
   end

   // registered pull-up control and interrupt feed
   always @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         port0_pullup_on <= 8'h00;
         ext_irq_in      <= 8'h00;
      end
      else
      begin
         port0_pullup_on <= next_pullup_on;
         ext_irq_in      <= next_irq_in;
      end
   end

endmodule // p0g_port

`default_nettype wire

// File: verif/p0g_checker.sv
// Purpose: port-level assertions for the port 0 pin block
// Assumes: one pclk domain, presetn asynchronous active low
// Notes:   pad outputs trail register writes by one edge
`timescale 1ns/1ns
`default_nettype none
`include "p0g_consts.vh"
module p0g_checker
(
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        stop_mode,
   input wire logic        watch_mode,
   input wire logic [7:0]  port0_pin_in,
   input wire logic [7:0]  port0_pin_out,
   input wire logic [7:0]  port0_pin_oe,
   input wire logic [7:0]  port0_pullup_on,
   input wire logic [7:0]  ext_irq_in
);
   // completed write, outside standby
   wire wr = psel & penable & pready & pwrite & pstrb[0] &
             !stop_mode & !watch_mode;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // -------------------------------------------------------------
   // properties
   // -------------------------------------------------------------
   property p_rdy; psel && !penable |=> pready; endproperty
   a_rdy: assert property (p_rdy)
      else $error("pready missing after setup");
   property p_pulse; pready |=> !pready; endproperty
   a_pulse: assert property (p_pulse)
      else $error("pready longer than one cycle");
   property p_rst; $rose(presetn) |->
      (port0_pin_oe | port0_pullup_on | port0_pin_out) == 8'h00;
   endproperty
   a_rst: assert property (p_rst)
      else $error("pad outputs not clear after reset");
   property p_dir; wr && paddr == `P0G_OFS_DIR |->
      ##2 port0_pin_oe == $past(pwdata[7:0], 2); endproperty
   a_dir: assert property (p_dir)
      else $error("output enable not following direction");
   property p_lat; wr && paddr == `P0G_OFS_OUT_LATCH |->
      ##2 port0_pin_out == $past(pwdata[7:0], 2); endproperty
   a_lat: assert property (p_lat)
      else $error("drive value not following latch");
   property p_pu;
      (port0_pullup_on & port0_pin_oe & ~port0_pin_out) == 8'h00;
   endproperty
   a_pu: assert property (p_pu)
      else $error("pull-up on while driving low");
   property p_err; pready && paddr > `P0G_OFS_IRQ_EN |-> pslverr;
   endproperty
   a_err: assert property (p_err)
      else $error("no error on unmapped address");
   property p_errp; pslverr |-> pready; endproperty
   a_errp: assert property (p_errp)
      else $error("error flag without pready");
   property p_irq; !stop_mode && !watch_mode && $past(presetn, 3)
      |-> ext_irq_in == $past(port0_pin_in, 3); endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt input not following pin");
   property p_rd; pready |-> prdata[31:8] == 24'h000000; endproperty
   a_rd: assert property (p_rd)
      else $error("read data above bit 7 not zero");
endmodule // p0g_checker
bind p0g_port p0g_checker u_chk
(
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .stop_mode(stop_mode), .watch_mode(watch_mode),
   .port0_pin_in(port0_pin_in), .port0_pin_out(port0_pin_out),
   .port0_pin_oe(port0_pin_oe), .port0_pullup_on(port0_pullup_on),
   .ext_irq_in(ext_irq_in)
);
`default_nettype wire

// File: verif/p0g_pins.sv
// Purpose: board-side model of the eight port 0 pins
// Assumes: bench may also drive a pin the block is driving; block drive wins
// Notes:   an unpulled released pin toggles, never holds
`timescale 1ns/1ns
`default_nettype none
module p0g_pins
(
   input  wire logic       pclk,
   input  wire logic [7:0] pin_out,
   input  wire logic [7:0] pin_oe,
   input  wire logic [7:0] pull_on,
   input  wire logic [7:0] ext_val,
   input  wire logic [7:0] ext_en,
   output logic      [7:0] pin_in
);
   logic [7:0] flt = 8'h00;
   // floating level wanders so a stale value cannot pass
   always @(posedge pclk) flt <= ~pin_in;
   // block drive first, then board, then pull-up
   always_comb
      for (int i = 0; i < 8; i++)
         pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i]
                     : pull_on[i] ? 1'b1 : flt[i];
endmodule // p0g_pins
`default_nettype wire

// File: verif/port0_gpio_with_pullup_tb.sv
// Purpose: self-checking bench for the port 0 pin block
// Assumes: APB master on pclk, pins modelled by p0g_pins
// Notes:   standby scenario runs last, stop is never left
`timescale 1ns/1ns
`default_nettype none
`include "p0g_consts.vh"
module port0_gpio_with_pullup_tb;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
   logic        penable = 1'b0, pwrite = 1'b0, err;
   logic        stop_mode = 1'b0, watch_mode = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000, q;
   logic [3:0]  pstrb = 4'hF;
   logic [7:0]  ext_val = 8'h00, ext_en = 8'h00;
   wire  [31:0] prdata;
   wire         pready, pslverr;
   wire  [7:0]  pin_in, pin_out, pin_oe, pull_on, irq;
   int          n_errors = 0, comparisons = 0;
   p0g_port uut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .stop_mode(stop_mode),
      .watch_mode(watch_mode), .port0_pin_in(pin_in),
      .port0_pin_out(pin_out), .port0_pin_oe(pin_oe),
      .port0_pullup_on(pull_on), .ext_irq_in(irq));
   p0g_pins pins (.pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe),
      .pull_on(pull_on), .ext_val(ext_val), .ext_en(ext_en),
      .pin_in(pin_in));
   // -------------------------------------------------------------
   // bus and compare tasks
   // -------------------------------------------------------------
   task chk(input string nm, input logic [31:0] e, g);
      comparisons++;
      if (g !== e)
      begin
         n_errors++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask
   // request held until pready is seen at an edge
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // no local limit: only the watchdog may end a stuck wait
      do
      begin
         @(posedge pclk);
      end
      while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task rdc(input logic [11:0] a, input logic [31:0] e, input string nm);
      apb(1'b0, a, 32'h00000000);
      chk(nm, e, q);
   endtask
   // -------------------------------------------------------------
   // scenarios
   // -------------------------------------------------------------
   task t_regs;
      rdc(`P0G_OFS_DIR, 32'h00, "dir");
      rdc(`P0G_OFS_PULLUP_EN, 32'h00, "pull");
      rdc(`P0G_OFS_RMW_LATCH, 32'h00, "latch");
      apb(1'b1, `P0G_OFS_DIR, 32'hFFFFFFA5);
      apb(1'b1, `P0G_OFS_PULLUP_EN, 32'h0000005A);
      rdc(`P0G_OFS_DIR, 32'hA5, "dir");
      rdc(`P0G_OFS_PULLUP_EN, 32'h5A, "pull");
      // low byte lane off: write completes but changes nothing
      pstrb <= 4'hE;
      apb(1'b1, `P0G_OFS_DIR, 32'h00);
      pstrb <= 4'hF;
      rdc(`P0G_OFS_DIR, 32'hA5, "dir_strb");
   endtask
   task t_in;
      ext_en <= 8'hFF;
      ext_val <= 8'hC3;
      apb(1'b1, `P0G_OFS_PULLUP_EN, 32'h00);
      apb(1'b1, `P0G_OFS_DIR, 32'h00);
      apb(1'b1, `P0G_OFS_OUT_LATCH, 32'h3C);
      repeat (6) @(posedge pclk);
      chk("oe", 8'h00, pin_oe);
      chk("irq", 8'hC3, irq);
      rdc(`P0G_OFS_OUT_LATCH, 32'hC3, "pins");
      rdc(`P0G_OFS_RMW_LATCH, 32'h3C, "latch");
   endtask
   task t_out;
      ext_en <= 8'h00;
      apb(1'b1, `P0G_OFS_DIR, 32'hFF);
      apb(1'b1, `P0G_OFS_OUT_LATCH, 32'h5A);
      repeat (6) @(posedge pclk);
      chk("out", 8'h5A, pin_out);
      chk("oe", 8'hFF, pin_oe);
      rdc(`P0G_OFS_OUT_LATCH, 32'h5A, "pins");
   endtask
   task t_pull;
      apb(1'b1, `P0G_OFS_PULLUP_EN, 32'hFF);
      repeat (2) @(posedge pclk);
      chk("pull_on", 8'h5A, pull_on);
      apb(1'b1, `P0G_OFS_DIR, 32'h00);
      repeat (6) @(posedge pclk);
      rdc(`P0G_OFS_OUT_LATCH, 32'hFF, "pins");
      // unmapped place is only read, never written
      apb(1'b0, 12'h040, 32'h00);
      chk("pslverr", 1'b1, err);
   endtask
   task t_stby;
      apb(1'b1, `P0G_OFS_DIR, 32'hFF);
      apb(1'b1, `P0G_OFS_IRQ_EN, 32'h01);
      apb(1'b1, `P0G_OFS_STANDBY, 32'h01);
      watch_mode <= 1'b1;
      repeat (3) @(posedge pclk);
      ext_en <= 8'hFF;
      ext_val <= 8'h81;
      repeat (6) @(posedge pclk);
      chk("oe", 8'h00, pin_oe);
      chk("pull_on", 8'h00, pull_on);
      chk("irq", 8'h01, irq);
      rdc(`P0G_OFS_OUT_LATCH, 32'h01, "pins_flt");
      // watch hands over to stop at one edge, float must stay
      watch_mode <= 1'b0;
      stop_mode <= 1'b1;
      ext_val <= 8'h7E;
      repeat (6) @(posedge pclk);
      chk("oe", 8'h00, pin_oe);
      chk("irq", 8'h00, irq);
   endtask
   task end_sim;
      if (n_errors == 0 && comparisons > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // clock, 10 ns period
   initial
   begin
      forever #5 pclk = ~pclk;
   end
   // hang guard, far beyond the roughly 130 cycles used
   initial
   begin
      #100000;
      n_errors++;
      end_sim;
   end
   // reset, then scenarios in order
   initial
   begin
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_in;
      t_out;
      t_pull;
      t_stby;
      end_sim;
   end
endmodule // port0_gpio_with_pullup_tb
`default_nettype wire
